// file: hw/adcc_pkg.sv
// Constants, register map and carrier types of the converter control block.
package adcc_pkg;

   // ********************
   // Register offsets (byte addresses)
   // ********************
   localparam logic [11:0] OFS_INT_STATUS = 12'h060;
   localparam logic [11:0] OFS_INT_ENABLE = 12'h064;
   localparam logic [11:0] OFS_RESULT_BASE = 12'h070;
   localparam logic [11:0] OFS_RESULT_LAST = 12'h0ac;
   localparam logic [11:0] OFS_CAL_OFFSET = 12'h0c0;
   localparam logic [11:0] OFS_CAL_PN = 12'h0cc;
   localparam logic [11:0] OFS_CAL_NM = 12'h0d8;
   localparam logic [11:0] OFS_DMA_SOURCE = 12'h0e0;
   localparam logic [11:0] OFS_CONTROL_ONE = 12'h0e8;
   localparam logic [11:0] OFS_CONTROL_TWO = 12'h0ec;
   localparam logic [11:0] OFS_LIMIT_LOW = 12'h0f4;
   localparam logic [11:0] OFS_LIMIT_HIGH = 12'h0f8;
   localparam logic [11:0] OFS_LIMIT_STATUS = 12'h0fc;
   localparam logic [11:0] OFS_TEMP_GAIN = 12'h100;
   localparam logic [11:0] OFS_AVG_SKIP = 12'h104;
   localparam logic [11:0] OFS_DATA_PATH = 12'h108;
   localparam logic [11:0] OFS_STATE = 12'h10c;

   // ********************
   // Reset values and writable masks
   // ********************
   localparam logic [31:0] RST_CONTROL_ONE = 32'h0000_00c0;
   localparam logic [31:0] RST_TEMP_GAIN = 32'h546a_546a;
   localparam logic [31:0] RST_AVG_SKIP = 32'h7000_0000;
   localparam logic [31:0] RST_DATA_PATH = 32'h8000_0000;
   localparam logic [31:0] WR_MASK_CONTROL_TWO = 32'hffff_f35f;
   localparam logic [31:0] WR_MASK_AVG_SKIP = 32'h08f7_ffff;
   localparam logic [31:0] WR_MASK_DATA_PATH = 32'hc000_0000;
   localparam logic [31:0] WR_MASK_LIMIT_STATUS = 32'h00ff_ffff;

   // ********************
   // Field positions
   // ********************
   localparam int BIT_ENABLE = 0;
   localparam int BIT_SOFT_RESET = 1;
   localparam int BIT_BUSY = 5;
   localparam int BIT_CAL_ARM = 6;
   localparam int BIT_CAL_DONE = 7;
   localparam int BIT_CAL_FAULT_CLR = 8;
   localparam int BIT_CONV_FAULT_CLR = 9;
   localparam int BIT_CAL_FAULT = 10;
   localparam int BIT_CONV_FAULT = 11;
   localparam int POS_MASK = 16;
   localparam int POS_LIMIT_EN = 8;
   localparam int POS_LIMIT_STAT = 24;
   localparam int POS_LIMIT_COND = 16;
   localparam int POS_INT_FLAGS = 14;
   localparam int POS_SKIP = 20;
   localparam int POS_AVG_CODE = 16;

   // ********************
   // Behaviour constants
   // ********************
   localparam logic [3:0] TEMP_CHANNEL = 4'ha;
   localparam logic [15:0] DEFAULT_SCAN = 16'h0fff;
   localparam int CAL_CYCLES = 4096;
   localparam logic [2:0] STATE_IDLE = 3'h0;
   localparam logic [2:0] STATE_AUTO = 3'h2;
   localparam logic [2:0] STATE_MANUAL = 3'h4;
   localparam logic [2:0] AVG_CODE_MAX = 3'h5;

   typedef enum logic [1:0] {
      CAL_IDLE = 2'b00,
      CAL_RUN = 2'b01,
      CAL_DONE = 2'b11
   } adcc_cal_t;

   typedef struct packed {
      logic [3:0] ch;
      logic [15:0] data;
   } adcc_sample_t;

   typedef struct packed {
      logic [8:0] offs;
      logic [31:0] pn;
      logic [8:0] nm;
   } adcc_cal_res_t;

endpackage : adcc_pkg

// file: hw/adcc_ctrl.sv
// Digital control, result and limit logic around the analog converter core.
//
// How it works
// R1: Temperature sensor powered only when channel 10 selected.
// R2: Software converts temperature channel alone, 2us setup.
// R3: Control one bits 31:16 enable channel dividers.
// R4: Scan mask in control two; zero scans twelve.
// R5: Conversion fault flag bit 11, cleared by bit 9.
// R6: Calibration fault flag bit 10 set on calibration error.
// R7: Done flag bit 7; cleared by resets.
// R8: Arm bit 6 lets enable write start calibration.
// R9: Busy bit 5 while calibrating, sampling or converting.
// R10: Soft reset bit 1 keeps calibration results.
// R11: Enable sampled on falling edge; zero shuts down.
// R12: Software waits 100us after enable before converting.
// R13: Software disables only when idle, then checks status.
// R14: Four comparators check shifted result against limits.
// R15: Limit status bits 31:24 show above/below state.
// R16: Two-bit trigger condition per comparator.
// R17: Four-bit channel select per comparator.
// R18: Sixteen-bit signed result per channel register.
// R19: Skip 0 to 15 initial samples.
// R20: Per-channel averaging of 2 to 64 points.
// R21: Self-calibration lasts 4096 clock cycles.
// R22: Software programs gain coefficients and data setting.
// R23: Calibration fault cleared by clear bit held.
// R24: Limit events set sticky flags, write one clears.
// R25: Converter state code: 0 idle, 2 auto, 4 manual.
// R26: Limits evaluated in the cycle a result lands.
`timescale 1ns/10ps
`default_nettype none

module adcc_ctrl
   import adcc_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk_in,
   input wire logic reset_in,
   // Register port
   input wire logic [11:0] reg_addr_in,
   input wire logic [31:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [31:0] reg_rdata_out,
   // Converter core status and data
   input wire logic sample_valid_in,
   input wire adcc_sample_t sample_in,
   input wire logic [3:0] selected_channel_in,
   input wire logic core_busy_in,
   input wire logic core_auto_in,
   input wire logic core_manual_in,
   input wire logic conv_fault_in,
   input wire logic cal_fault_in,
   input wire adcc_cal_res_t cal_result_in,
   // Converter core control
   output logic core_enable_out,
   output logic core_reset_out,
   output logic cal_active_out,
   output logic temp_sensor_power_out,
   output logic [15:0] divider_enable_mask_out,
   output logic [15:0] scan_channel_mask_out,
   output logic [1:0] data_path_setting_out
);

   // ********************
   // Helper functions
   // ********************
   // Right shift that turns an average sum back into one sample.
   function automatic logic [2:0] avg_shift(input logic [2:0] code);
      logic [2:0] c;
      c = (code > AVG_CODE_MAX) ? AVG_CODE_MAX : code;
      return 3'(c + 3'h1);
   endfunction : avg_shift

   function automatic logic limit_trig(input logic [1:0] cond, input logic old_f,
                                       input logic new_f);
      logic t;
      unique case (cond)
         2'h0: t = new_f;
         2'h1: t = new_f & ~old_f;
         2'h2: t = old_f & ~new_f;
         2'h3: t = new_f ^ old_f;
      endcase
      return t;
   endfunction : limit_trig

   // ********************
   // Registers
   // ********************
   logic [31:0] ctrl1_r, ctrl2_r, lim_low_r, lim_high_r, lim_sel_r;
   logic [31:0] gain_r, avg_skip_r, data_path_r;
   logic [7:0] int_en_r, int_flags_r, lim_stat_r;
   logic [15:0] result_r [16];
   logic [15:0] dma_r;
   logic conv_fault_r, cal_fault_r, en_sampled_r;
   adcc_cal_t cal_state_r;
   logic [11:0] cal_cnt_r;
   adcc_cal_res_t cal_res_r;
   logic signed [21:0] acc_r;
   logic [6:0] avg_cnt_r;
   logic [3:0] avg_ch_r, skip_cnt_r;
   logic [31:0] rdata_nxt;

   logic soft_rst, wr_ctrl2, wr_intsts, cal_start, cal_end;
   logic [2:0] conv_state;
   logic [3:0] skip_code;
   logic [2:0] shift;
   logic [6:0] points, base_cnt;
   logic signed [21:0] base_acc, sum;
   logic take, skipping, avg_on, res_we;
   logic [15:0] res_val;
   logic [3:0] res_ch;
   logic [7:0] lim_stat_nxt, lim_evt;
   logic [63:0] limits;

   assign soft_rst = reset_in | ctrl2_r[BIT_SOFT_RESET]; // R10
   assign wr_ctrl2 = reg_wr_in && reg_addr_in == OFS_CONTROL_TWO;
   assign wr_intsts = reg_wr_in && reg_addr_in == OFS_INT_STATUS;
   assign cal_start = wr_ctrl2 && reg_wdata_in[BIT_ENABLE] && ctrl2_r[BIT_CAL_ARM]; // R8
   assign cal_end = cal_state_r == CAL_RUN && cal_cnt_r == 12'(CAL_CYCLES - 1); // R21
   assign conv_state = core_manual_in ? STATE_MANUAL :
                       core_auto_in ? STATE_AUTO : STATE_IDLE; // R25

   // ********************
   // Software-written registers
   // ********************
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         ctrl1_r <= RST_CONTROL_ONE;
         ctrl2_r <= '0;
         lim_low_r <= '0;
         lim_high_r <= '0;
         lim_sel_r <= '0;
         gain_r <= RST_TEMP_GAIN;
         avg_skip_r <= RST_AVG_SKIP;
         data_path_r <= RST_DATA_PATH;
         int_en_r <= '0;
      end else if (reg_wr_in) begin
         unique case (reg_addr_in)
            OFS_CONTROL_ONE: ctrl1_r <= reg_wdata_in; // R3 R14
            OFS_CONTROL_TWO: ctrl2_r <= reg_wdata_in & WR_MASK_CONTROL_TWO;
            OFS_LIMIT_LOW: lim_low_r <= reg_wdata_in;
            OFS_LIMIT_HIGH: lim_high_r <= reg_wdata_in;
            OFS_LIMIT_STATUS: lim_sel_r <= reg_wdata_in & WR_MASK_LIMIT_STATUS;
            OFS_TEMP_GAIN: gain_r <= reg_wdata_in;
            OFS_AVG_SKIP: avg_skip_r <= (reg_wdata_in & WR_MASK_AVG_SKIP) | RST_AVG_SKIP;
            OFS_DATA_PATH: data_path_r <= reg_wdata_in & WR_MASK_DATA_PATH;
            OFS_INT_ENABLE: int_en_r <= reg_wdata_in[POS_INT_FLAGS +: 8];
            default: ;
         endcase
      end
   end

   // ********************
   // Enable sampling on the falling edge
   // ********************
   always_ff @(negedge sys_clk_in) begin
      if (reset_in) begin
         en_sampled_r <= 1'b0;
      end else begin
         en_sampled_r <= ctrl2_r[BIT_ENABLE]; // R11
      end
   end

   // ********************
   // Self-calibration sequencer
   // ********************
   always_ff @(posedge sys_clk_in) begin
      if (soft_rst) begin
         cal_state_r <= CAL_IDLE; // R7
         cal_cnt_r <= '0;
      end else begin
         unique case (cal_state_r)
            CAL_IDLE, CAL_DONE: begin
               cal_cnt_r <= '0;
               if (cal_start) begin
                  cal_state_r <= CAL_RUN; // R8
               end
            end
            CAL_RUN: begin
               cal_cnt_r <= 12'(cal_cnt_r + 12'h1);
               if (cal_end) begin
                  cal_state_r <= CAL_DONE; // R7 R21
               end
            end
            default: cal_state_r <= CAL_IDLE;
         endcase
      end
   end

   // Calibration results survive the soft reset and a disable.
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         cal_res_r <= '0;
      end else if (cal_end) begin
         cal_res_r <= cal_result_in; // R10 R11
      end
   end

   // ********************
   // Fault flags
   // ********************
   // A fault in the cycle of a clear still sets the flag.
   always_ff @(posedge sys_clk_in) begin
      if (soft_rst) begin
         conv_fault_r <= 1'b0;
         cal_fault_r <= 1'b0;
      end else begin
         if (conv_fault_in) begin
            conv_fault_r <= 1'b1; // R5
         end else if (ctrl2_r[BIT_CONV_FAULT_CLR]) begin
            conv_fault_r <= 1'b0; // R5
         end
         if (cal_fault_in && cal_state_r == CAL_RUN) begin
            cal_fault_r <= 1'b1; // R6
         end else if (ctrl2_r[BIT_CAL_FAULT_CLR]) begin
            cal_fault_r <= 1'b0; // R23
         end
      end
   end

   // ********************
   // Skip and averaging path
   // ********************
   always_comb begin
      skip_code = avg_skip_r[POS_SKIP +: 4];
      shift = avg_shift(avg_skip_r[POS_AVG_CODE +: 3]);
      points = 7'(7'h1 << shift);
      take = sample_valid_in && en_sampled_r && cal_state_r != CAL_RUN;
      skipping = skip_cnt_r < skip_code; // R19
      avg_on = avg_skip_r[sample_in.ch]; // R20
      base_acc = (sample_in.ch == avg_ch_r) ? acc_r : '0;
      base_cnt = (sample_in.ch == avg_ch_r) ? avg_cnt_r : '0;
      sum = base_acc + 22'(signed'(sample_in.data));
      res_we = take && !skipping && (!avg_on || base_cnt == 7'(points - 7'h1));
      res_val = avg_on ? 16'(sum >>> shift) : sample_in.data; // R20
      res_ch = sample_in.ch;
   end

   always_ff @(posedge sys_clk_in) begin
      if (soft_rst || !core_busy_in) begin
         skip_cnt_r <= '0; // R19
         acc_r <= '0;
         avg_cnt_r <= '0;
         avg_ch_r <= '0;
      end else if (take) begin
         if (skipping) begin
            skip_cnt_r <= 4'(skip_cnt_r + 4'h1); // R19
         end else if (avg_on && !res_we) begin
            acc_r <= sum;
            avg_cnt_r <= 7'(base_cnt + 7'h1);
            avg_ch_r <= sample_in.ch;
         end else begin
            acc_r <= '0;
            avg_cnt_r <= '0;
         end
      end
   end

   // ********************
   // Result storage
   // ********************
   always_ff @(posedge sys_clk_in) begin
      if (soft_rst) begin
         for (int i = 0; i < 16; i++) begin
            result_r[i] <= '0;
         end
         dma_r <= '0;
      end else if (res_we) begin
         result_r[res_ch] <= res_val; // R18
         dma_r <= res_val;
      end
   end

   // ********************
   // Limit comparators
   // ********************
   always_comb begin
      logic [3:0] sel;
      logic signed [7:0] shifted, upper, lower;
      logic up, lo;
      sel = '0;
      shifted = '0;
      upper = '0;
      lower = '0;
      up = 1'b0;
      lo = 1'b0;
      limits = {lim_high_r, lim_low_r};
      lim_stat_nxt = lim_stat_r;
      lim_evt = '0;
      shifted = res_val[15:8]; // R14
      for (int k = 0; k < 4; k++) begin
         sel = lim_sel_r[4*k +: 4]; // R17
         upper = limits[16*k+8 +: 8];
         lower = limits[16*k +: 8];
         up = ctrl1_r[POS_LIMIT_EN+2*k+1] && shifted > upper; // R14
         lo = ctrl1_r[POS_LIMIT_EN+2*k] && shifted < lower; // R14
         if (res_we && res_ch == sel) begin
            lim_stat_nxt[2*k] = lo; // R26
            lim_stat_nxt[2*k+1] = up; // R26
            lim_evt[2*k] = limit_trig(lim_sel_r[POS_LIMIT_COND+2*k +: 2],
                                      lim_stat_r[2*k], lo); // R16
            lim_evt[2*k+1] = limit_trig(lim_sel_r[POS_LIMIT_COND+2*k +: 2],
                                        lim_stat_r[2*k+1], up); // R16
         end
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (soft_rst) begin
         lim_stat_r <= '0;
      end else begin
         lim_stat_r <= lim_stat_nxt; // R15
      end
   end

   // A new event wins over a write-one clear in the same cycle.
   always_ff @(posedge sys_clk_in) begin
      if (soft_rst) begin
         int_flags_r <= '0;
      end else begin
         int_flags_r <= (int_flags_r
                         & ~(wr_intsts ? reg_wdata_in[POS_INT_FLAGS +: 8] : 8'h00))
                        | (lim_evt & int_en_r); // R24
      end
   end

   // ********************
   // Core control outputs
   // ********************
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         core_enable_out <= 1'b0;
         core_reset_out <= 1'b1;
         cal_active_out <= 1'b0;
         temp_sensor_power_out <= 1'b0;
         divider_enable_mask_out <= '0;
         scan_channel_mask_out <= DEFAULT_SCAN;
         data_path_setting_out <= RST_DATA_PATH[31:30];
      end else begin
         core_enable_out <= en_sampled_r; // R11
         core_reset_out <= ctrl2_r[BIT_SOFT_RESET]; // R10
         cal_active_out <= cal_state_r == CAL_RUN;
         temp_sensor_power_out <= en_sampled_r && selected_channel_in == TEMP_CHANNEL; // R1
         divider_enable_mask_out <= ctrl1_r[POS_MASK +: 16]; // R3
         scan_channel_mask_out <= (ctrl2_r[POS_MASK +: 16] == '0) ? DEFAULT_SCAN
                                  : ctrl2_r[POS_MASK +: 16]; // R4
         data_path_setting_out <= data_path_r[31:30];
      end
   end

   // ********************
   // Register read
   // ********************
   always_comb begin
      rdata_nxt = '0;
      if (reg_addr_in >= OFS_RESULT_BASE && reg_addr_in <= OFS_RESULT_LAST
          && reg_addr_in[1:0] == 2'b00) begin
         rdata_nxt = {16'h0000, result_r[4'(reg_addr_in[11:2] - OFS_RESULT_BASE[11:2])]};
      end else begin
         unique case (reg_addr_in)
            OFS_INT_STATUS: rdata_nxt = {10'h000, int_flags_r, 14'h0000};
            OFS_INT_ENABLE: rdata_nxt = {10'h000, int_en_r, 14'h0000};
            OFS_CAL_OFFSET: rdata_nxt = {23'h000000, cal_res_r.offs};
            OFS_CAL_PN: rdata_nxt = cal_res_r.pn;
            OFS_CAL_NM: rdata_nxt = {23'h000000, cal_res_r.nm};
            OFS_DMA_SOURCE: rdata_nxt = {16'h0000, dma_r};
            OFS_CONTROL_ONE: rdata_nxt = ctrl1_r;
            OFS_CONTROL_TWO: begin
               rdata_nxt = ctrl2_r;
               rdata_nxt[BIT_CONV_FAULT] = conv_fault_r; // R5
               rdata_nxt[BIT_CAL_FAULT] = cal_fault_r; // R6
               rdata_nxt[BIT_CAL_DONE] = cal_state_r == CAL_DONE; // R7
               rdata_nxt[BIT_BUSY] = cal_state_r == CAL_RUN || core_busy_in; // R9
            end
            OFS_LIMIT_LOW: rdata_nxt = lim_low_r;
            OFS_LIMIT_HIGH: rdata_nxt = lim_high_r;
            OFS_LIMIT_STATUS: rdata_nxt = {lim_stat_r, lim_sel_r[23:0]}; // R15
            OFS_TEMP_GAIN: rdata_nxt = gain_r;
            OFS_AVG_SKIP: rdata_nxt = avg_skip_r;
            OFS_DATA_PATH: rdata_nxt = data_path_r;
            OFS_STATE: rdata_nxt = {27'h0000000, ctrl2_r[BIT_SOFT_RESET], en_sampled_r,
                                    conv_state}; // R25
            default: rdata_nxt = '0;
         endcase
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         reg_rdata_out <= '0;
      end else begin
         reg_rdata_out <= reg_rd_in ? rdata_nxt : 32'h0000_0000;
      end
   end

endmodule : adcc_ctrl

`default_nettype wire

// file: tb/adcc_core_model.sv
// Behavioural model of the analog converter core.
`timescale 1ns/10ps
`default_nettype none
module adcc_core_model
   import adcc_pkg::*;
(
   // Clock and bench commands
   input wire logic sys_clk_in,
   input wire logic go_in,
   input wire logic burst_in,
   input wire logic manual_in,
   input wire logic conversion_fault_flag_in,
   input wire logic cal_err_in,
   input wire adcc_sample_t cmd_in,
   // Block side
   input wire logic core_enable_in,
   input wire logic cal_active_in,
   output logic sample_valid_out,
   output adcc_sample_t sample_out,
   output logic [3:0] sel_out,
   output logic busy_out,
   output logic auto_out,
   output logic manual_out,
   output logic conv_fault_out,
   output logic cal_fault_out,
   output adcc_cal_res_t cal_res_out
);
   assign cal_res_out = {9'h15b, 32'h89ab_cdef, 9'h0a6};
   always @(posedge sys_clk_in) begin
      sample_valid_out <= go_in && burst_in && core_enable_in;
      // Between strobes the bus toggles so stale data never looks valid.
      sample_out <= go_in ? cmd_in : ~sample_out;
      sel_out <= cmd_in.ch;
      busy_out <= burst_in;
      auto_out <= burst_in && !manual_in;
      manual_out <= burst_in && manual_in;
      conv_fault_out <= burst_in && conversion_fault_flag_in;
      cal_fault_out <= cal_active_in && cal_err_in;
   end
endmodule : adcc_core_model
`default_nettype wire

// file: tb/adcc_ctrl_assertions.sv
// Port-level checks of the converter control block.
`timescale 1ns/10ps
`default_nettype none
module adcc_ctrl_assertions
   import adcc_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk_in,
   input wire logic reset_in,
   // Register port
   input wire logic [11:0] reg_addr_in,
   input wire logic [31:0] reg_wdata_in,
   input wire logic reg_wr_in,
   // Converter side
   input wire logic [3:0] selected_channel_in,
   input wire logic core_enable_out,
   input wire logic core_reset_out,
   input wire logic cal_active_out,
   input wire logic temp_sensor_power_out,
   input wire logic [15:0] scan_channel_mask_out,
   input wire logic [1:0] data_path_setting_out
);
   logic wr_two;
   logic arm_r;
   logic [12:0] cal_len_r;
   assign wr_two = reg_wr_in && reg_addr_in == OFS_CONTROL_TWO;
   always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
         arm_r <= 1'b0;
      end else if (wr_two) begin
         arm_r <= reg_wdata_in[BIT_CAL_ARM];
      end
   end
   always_ff @(posedge sys_clk_in) begin
      if (reset_in || !cal_active_out) begin
         cal_len_r <= 13'h0;
      end else begin
         cal_len_r <= cal_len_r + 13'h1;
      end
   end
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (reset_in);
   a_reset_outputs: assert property ($fell(reset_in) |-> core_reset_out && !cal_active_out
      && scan_channel_mask_out == DEFAULT_SCAN && data_path_setting_out == 2'h2)
      else $error("outputs wrong after reset");
   a_scan_mask: assert property (wr_two ##1 !wr_two |=> scan_channel_mask_out ==
      ($past(reg_wdata_in[31:16], 2) != 16'h0 ? $past(reg_wdata_in[31:16], 2) : DEFAULT_SCAN))
      else $error("scan mask wrong");
   a_cal_start: assert property (wr_two && reg_wdata_in[BIT_ENABLE] && arm_r
      |=> ##1 cal_active_out) else $error("calibration did not start");
   a_cal_length: assert property ($fell(cal_active_out) |-> cal_len_r == CAL_CYCLES)
      else $error("calibration length wrong");
   a_soft_reset: assert property ((wr_two && reg_wdata_in[BIT_SOFT_RESET]) ##1 !wr_two
      |=> core_reset_out) else $error("soft reset not passed on");
   a_enable_on: assert property ((wr_two && reg_wdata_in[BIT_ENABLE]) ##1 (!wr_two)[*2]
      |=> core_enable_out) else $error("enable not passed on");
   a_temp_off: assert property (selected_channel_in != TEMP_CHANNEL
      |=> !temp_sensor_power_out) else $error("sensor powered on other channel");
   a_temp_on: assert property ((core_enable_out && selected_channel_in == TEMP_CHANNEL)[*2]
      ##1 core_enable_out |-> temp_sensor_power_out) else $error("sensor not powered");
endmodule : adcc_ctrl_assertions
bind adcc_ctrl adcc_ctrl_assertions u_adcc_ctrl_assertions (.*);
`default_nettype wire

// file: tb/tb_adc_digital_control.sv
// Self-checking bench of the converter control block.
`timescale 1ns/10ps
`default_nettype none
module tb_adc_digital_control import adcc_pkg::*; ;
   logic sys_clk_in = 1'b0, reset_in = 1'b1;
   logic [11:0] reg_addr_in = '0;
   logic [31:0] reg_wdata_in = '0;
   logic reg_wr_in = 1'b0, reg_rd_in = 1'b0;
   logic [31:0] reg_rdata_out;
   logic sample_valid_in, core_busy_in, core_auto_in, core_manual_in, conv_fault_in, cal_fault_in;
   adcc_sample_t sample_in;
   adcc_cal_res_t cal_result_in;
   logic [3:0] selected_channel_in;
   logic core_enable_out, core_reset_out, cal_active_out, temp_sensor_power_out;
   logic [15:0] divider_enable_mask_out, scan_channel_mask_out;
   logic [1:0] data_path_setting_out;
   logic go = 1'b0, burst = 1'b0, man = 1'b0, cerr = 1'b0, kerr = 1'b0;
   adcc_sample_t cmd = '0;
   logic [63:0] lims;
   logic [31:0] d, flg;
   logic [15:0] sl = 16'h5533;
   logic [3:0] ch;
   logic [1:0] nw, ev;
   logic [1:0] st [4] = '{default: 2'b00};
   int mismatches = 0;
   int n_tests = 0;
   int seed = 45387;
   int n, c, i, k, sum;
   always #2.5 sys_clk_in = ~sys_clk_in;
   adcc_ctrl dut (.*);
   adcc_core_model u_core (.sys_clk_in(sys_clk_in), .go_in(go), .burst_in(burst),
      .manual_in(man), .conversion_fault_flag_in(cerr), .cal_err_in(kerr), .cmd_in(cmd),
      .core_enable_in(core_enable_out), .cal_active_in(cal_active_out),
      .sample_valid_out(sample_valid_in), .sample_out(sample_in), .sel_out(selected_channel_in),
      .busy_out(core_busy_in), .auto_out(core_auto_in), .manual_out(core_manual_in),
      .conv_fault_out(conv_fault_in), .cal_fault_out(cal_fault_in), .cal_res_out(cal_result_in));
   task automatic check(input logic [31:0] seen, exp);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic wreg(input logic [11:0] a, input logic [31:0] v);
      @(posedge sys_clk_in);
      reg_addr_in <= a;
      reg_wdata_in <= v;
      reg_wr_in <= 1'b1;
      @(posedge sys_clk_in);
      reg_wr_in <= 1'b0;
   endtask : wreg
   task automatic rchk(input logic [11:0] a, input logic [31:0] m, e);
      @(posedge sys_clk_in);
      reg_addr_in <= a;
      reg_rd_in <= 1'b1;
      @(posedge sys_clk_in);
      reg_rd_in <= 1'b0;
      #1 check(reg_rdata_out & m, e);
   endtask : rchk
   task automatic put(input logic [3:0] c, input logic [15:0] v);
      @(posedge sys_clk_in);
      cmd <= '{ch: c, data: v};
      go <= 1'b1;
      @(posedge sys_clk_in);
      go <= 1'b0;
      @(posedge sys_clk_in);
   endtask : put
   function automatic logic [1:0] lim(input logic [15:0] v, input logic [15:0] l);
      return {$signed(v[15:8]) > $signed(l[15:8]), $signed(v[15:8]) < $signed(l[7:0])};
   endfunction : lim
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : finish_test
   initial begin
      repeat (80000) @(posedge sys_clk_in);
      mismatches++;
      finish_test();
   end
   initial begin
      repeat (4) @(posedge sys_clk_in);
      reset_in <= 1'b0;
      rchk(OFS_CONTROL_ONE, '1, RST_CONTROL_ONE);
      rchk(OFS_AVG_SKIP, '1, RST_AVG_SKIP);
      rchk(OFS_CONTROL_TWO, '1, 32'h0);
      rchk(12'h200, '1, 32'h0);
      wreg(OFS_TEMP_GAIN, 32'h599a_599a);
      rchk(OFS_TEMP_GAIN, '1, 32'h599a_599a);
      check(data_path_setting_out, 2'h2);
      d = $random(seed);
      wreg(OFS_CONTROL_ONE, d);
      rchk(OFS_CONTROL_ONE, '1, d);
      check(divider_enable_mask_out, d[31:16]);
      wreg(OFS_CONTROL_TWO, {d[15:0], 16'h0011});
      rchk(OFS_CONTROL_TWO, 32'hffff_0000, {d[15:0], 16'h0});
      check(cal_active_out, 1'b0);
      wreg(OFS_CONTROL_TWO, 32'h50);
      kerr <= 1'b1;
      wreg(OFS_CONTROL_TWO, 32'h51);
      rchk(OFS_CONTROL_TWO, 32'h20, 32'h20);
      for (n = 0; n < 5000 && cal_active_out !== 1'b0; n++) @(posedge sys_clk_in);
      kerr <= 1'b0;
      rchk(OFS_CONTROL_TWO, 32'h4a0, 32'h480);
      rchk(OFS_STATE, 32'h7, STATE_IDLE);
      wreg(OFS_CONTROL_TWO, 32'h10);
      rchk(OFS_STATE, 32'h8, 32'h0);
      wreg(OFS_CONTROL_TWO, 32'h110);
      wreg(OFS_CONTROL_TWO, 32'h10);
      rchk(OFS_CONTROL_TWO, 32'h400, 32'h0);
      wreg(OFS_CONTROL_TWO, 32'h12);
      wreg(OFS_CONTROL_TWO, 32'h10);
      rchk(OFS_CONTROL_TWO, 32'h80, 32'h0);
      rchk(OFS_CAL_OFFSET, 32'h1ff, 32'h15b);
      wreg(OFS_CONTROL_TWO, 32'h11);
      repeat (20000) @(posedge sys_clk_in);
      lims = {$random(seed), $random(seed)};
      wreg(OFS_LIMIT_LOW, lims[31:0]);
      wreg(OFS_LIMIT_HIGH, lims[63:32]);
      wreg(OFS_CONTROL_ONE, 32'h0000_ffc0);
      wreg(OFS_INT_ENABLE, 32'h003f_c000);
      for (c = 0; c < 4; c++) begin
         wreg(OFS_LIMIT_STATUS, {8'h0, {4{c[1:0]}}, sl});
         wreg(OFS_INT_STATUS, 32'h003f_c000);
         man <= (c == 3);
         burst <= 1'b1;
         flg = '0;
         for (i = 0; i < 6; i++) begin
            d = $random(seed);
            ch = d[16] ? 4'h3 : 4'h5;
            put(ch, d[15:0]);
            for (k = 0; k < 4; k++) begin
               if (sl[4*k +: 4] == ch) begin
                  nw = lim(d[15:0], lims[16*k +: 16]);
                  ev = c == 0 ? nw : c == 1 ? nw & ~st[k] : c == 2 ? st[k] & ~nw : nw ^ st[k];
                  flg[14 + 2*k +: 2] |= ev;
                  st[k] = nw;
               end
            end
            rchk(OFS_LIMIT_STATUS, 32'hff00_0000, {st[3], st[2], st[1], st[0], 24'h0});
            rchk(OFS_RESULT_BASE + {6'h0, ch, 2'h0}, 32'hffff, {16'h0, d[15:0]});
         end
         rchk(OFS_INT_STATUS, 32'h003f_c000, flg);
         rchk(OFS_STATE, 32'h7, c == 3 ? STATE_MANUAL : STATE_AUTO);
      end
      man <= 1'b0;
      cerr <= 1'b1;
      put(4'h3, 16'h0100);
      cerr <= 1'b0;
      rchk(OFS_CONTROL_TWO, 32'h800, 32'h800);
      wreg(OFS_CONTROL_TWO, 32'h211);
      wreg(OFS_CONTROL_TWO, 32'h11);
      rchk(OFS_CONTROL_TWO, 32'h800, 32'h0);
      for (c = 0; c < 3; c++) begin
         burst <= 1'b0;
         wreg(OFS_AVG_SKIP, {8'h0, 4'h4, 1'b0, c[2:0], 16'h0002});
         burst <= 1'b1;
         sum = 0;
         for (i = 0; i < 4 + (2 << c); i++) begin
            d = $random(seed);
            put(4'h1, d[15:0]);
            if (i >= 4) sum += int'($signed(d[15:0]));
         end
         rchk(OFS_RESULT_BASE + 12'h4, 32'hffff, (sum >>> (c + 1)) & 32'hffff);
      end
      burst <= 1'b0;
      cmd <= '{ch: TEMP_CHANNEL, data: 16'h0};
      repeat (4) @(posedge sys_clk_in);
      #1 check(temp_sensor_power_out, 1'b1);
      cmd <= '{ch: 4'h3, data: 16'h0};
      repeat (3) @(posedge sys_clk_in);
      #1 check(temp_sensor_power_out, 1'b0);
      finish_test();
   end
endmodule : tb_adc_digital_control
`default_nettype wire
